// ===== cilpc_ctrl.sv
`timescale 1ns/1ps
`include "cilpc_regs.svh"
// Overview of operation
// - interrupt entry stacks pc low, pc high, x, accumulator, flags in order
// - after the flags byte is stacked the interrupt mask bit is set
// - an instruction clearing the mask bit re-enables pending interrupts, allowing nesting
// - high index byte is never stacked on interrupt entry
// - software trap runs the same entry and ignores the mask bit
// - wait instruction clears the mask bit then gates cpu clocks
// - in wait an interrupt restarts clocks and is serviced normally
// - background command during wait restarts clocks and enters halted debug state
// - stop halts clocks; optionally a minimal clock set keeps running for wakeup
// - with debug enable set the oscillator stays on in stop
// - with debug enable set a background command in stop enters halted debug
// - debug entry instruction halts user execution in the debug state
// - only reset, resume, single-step or tagged resume leave the debug state
// - flags layout: V7, H4, I3, N2, Z1, C0
// - 16-bit operands are big-endian, low byte at address plus one
// - direct page operands use 0x00 as the high address byte
// - interrupts are taken only at an instruction boundary
module cilpc_ctrl (
  input wire logic sys_clk_i,
  input wire logic arst_n_i,
  input wire logic clk_en_i,
  input wire cilpc_pkg::cilpc_av_req_type av_req_i,
  output cilpc_pkg::cilpc_av_rsp_type av_rsp_o,
  input wire cilpc_pkg::cilpc_core_regs_type core_regs_i,
  input wire logic instr_done_i,
  input wire logic irq_req_i,
  input wire logic wake_i,
  input wire logic swi_exec_i,
  input wire logic wait_exec_i,
  input wire logic stop_exec_i,
  input wire logic debug_entry_instruction_exec_i,
  input wire logic flags_wr_i,
  input wire logic [7:0] flags_data_i,
  input wire logic dbg_cmd_valid_i,
  input wire cilpc_pkg::cilpc_cmd_type dbg_cmd_i,
  input wire logic dbg_strap_i,
  input wire logic opnd_req_i,
  input wire logic opnd_dir_i,
  input wire logic [15:0] opnd_addr_i,
  output logic [7:0] flags_o,
  output cilpc_pkg::cilpc_push_type push_o,
  output cilpc_pkg::cilpc_vec_type vec_o,
  output logic cpu_clk_en_o,
  output logic osc_en_o,
  output logic min_clk_en_o,
  output logic halted_o,
  output logic step_o,
  output logic dbg_en_o,
  output logic [15:0] opnd_hi_addr_o,
  output logic [15:0] opnd_lo_addr_o
);
  import cilpc_pkg::*;

  typedef struct packed {
    cilpc_state_type state;
    logic [2:0] idx;
    logic software_trap_instruction;
    logic [15:0] sp;
    logic [15:0] pc;
    logic [7:0] x;
    logic [7:0] a;
    logic [7:0] flags;
    logic dbg_en;
    logic keep_clk;
    logic strap_meta;
    logic strap_sync;
    logic [1:0] warm;
    logic halted;
    cilpc_av_rsp_type rsp;
    cilpc_push_type push;
    cilpc_vec_type vec;
    logic cpu_clk_en;
    logic osc_en;
    logic min_clk_en;
    logic step;
    logic [15:0] hi_addr;
    logic [15:0] lo_addr;
  } cilpc_ctrl_type;

  cilpc_ctrl_type s;
  cilpc_ctrl_type next_s;

  // reserved flag bits always read as zero
  function automatic logic [7:0] mask_flags(input logic [7:0] f);
    mask_flags = f & `CILPC_CC_MASK;
  endfunction : mask_flags

  function automatic logic [15:0] dir_addr(input logic [7:0] lo);
    dir_addr = {`CILPC_DIR_PAGE, lo};
  endfunction : dir_addr

  function automatic logic is_resume(input cilpc_cmd_type c);
    is_resume = (c == CILPC_CMD_RESUME) || (c == CILPC_CMD_STEP) ||
      (c == CILPC_CMD_TAGGED_RESUME);
  endfunction : is_resume

  logic bus_req;
  logic bus_go;
  logic is_bg_cmd;
  logic started;

  assign bus_req = av_req_i.read || av_req_i.write;
  assign bus_go = bus_req && !s.rsp.waitrequest;
  assign is_bg_cmd = dbg_cmd_valid_i && (dbg_cmd_i == CILPC_CMD_BACKGROUND);
  // strap is only valid once both synchroniser stages hold post-reset samples
  assign started = (s.warm == 2'h3);

  always_comb
  begin
    next_s = s;
    next_s.push.valid = 1'b0;
    next_s.vec.valid = 1'b0;
    next_s.step = 1'b0;
    next_s.strap_meta = dbg_strap_i;
    next_s.strap_sync = s.strap_meta;
    // saturating warm-up count; boundaries wait for it too
    if (!started)
    begin
      next_s.warm = s.warm + 2'h1;
    end
    else
    begin
      next_s.warm = s.warm;
    end

    // core-side flag updates; software writes below take the later word
    if (flags_wr_i)
    begin
      next_s.flags = mask_flags(flags_data_i);
    end
    if (dbg_cmd_valid_i && (dbg_cmd_i == CILPC_CMD_ENABLE))
    begin
      next_s.dbg_en = 1'b1;
    end

    unique case (s.state)
      CILPC_RUN:
      begin
        if (!started)
        begin
          // strap sampled at the first edge after release, seen at the third
          if (s.strap_sync)
          begin
            next_s.state = CILPC_HALT;
            next_s.dbg_en = 1'b1;
          end
        end
        else if (instr_done_i)
        begin
          next_s.pc = core_regs_i.pc;
          next_s.x = core_regs_i.x;
          next_s.a = core_regs_i.a;
          next_s.sp = core_regs_i.sp;
          next_s.idx = 3'h0;
          if (debug_entry_instruction_exec_i)
          begin
            next_s.state = CILPC_HALT;
          end
          else if (swi_exec_i)
          begin
            next_s.state = CILPC_PUSH;
            next_s.software_trap_instruction = 1'b1;
          end
          else if (irq_req_i && !s.flags[`CILPC_CC_I])
          begin
            next_s.state = CILPC_PUSH;
            next_s.software_trap_instruction = 1'b0;
          end
          else if (wait_exec_i)
          begin
            next_s.flags[`CILPC_CC_I] = 1'b0;
            next_s.state = CILPC_WAIT;
            next_s.cpu_clk_en = 1'b0;
          end
          else if (stop_exec_i)
          begin
            next_s.state = CILPC_STOP;
            next_s.cpu_clk_en = 1'b0;
            next_s.osc_en = s.dbg_en;
            next_s.min_clk_en = s.keep_clk;
          end
        end
      end
      CILPC_PUSH:
      begin
        next_s.push.valid = 1'b1;
        next_s.push.addr = s.sp - 16'(s.idx);
        // high index byte deliberately absent from the frame
        unique case (s.idx)
          3'h0: next_s.push.data = s.pc[7:0];
          3'h1: next_s.push.data = s.pc[15:8];
          3'h2: next_s.push.data = s.x;
          3'h3: next_s.push.data = s.a;
          default: next_s.push.data = s.flags;
        endcase
        if (s.idx == `CILPC_PUSH_LAST)
        begin
          next_s.flags[`CILPC_CC_I] = 1'b1;
          next_s.state = CILPC_VECTOR;
        end
        else
        begin
          next_s.idx = s.idx + 3'h1;
        end
      end
      CILPC_VECTOR:
      begin
        next_s.vec.valid = 1'b1;
        next_s.vec.software_trap_instruction = s.software_trap_instruction;
        next_s.state = CILPC_RUN;
      end
      CILPC_WAIT:
      begin
        if (is_bg_cmd)
        begin
          next_s.cpu_clk_en = 1'b1;
          next_s.state = CILPC_HALT;
        end
        else if (irq_req_i)
        begin
          // pc already points past the wait instruction
          next_s.cpu_clk_en = 1'b1;
          next_s.software_trap_instruction = 1'b0;
          next_s.idx = 3'h0;
          next_s.state = CILPC_PUSH;
        end
      end
      CILPC_STOP:
      begin
        if (is_bg_cmd && s.dbg_en)
        begin
          next_s.cpu_clk_en = 1'b1;
          next_s.osc_en = 1'b1;
          next_s.min_clk_en = 1'b0;
          next_s.state = CILPC_HALT;
        end
        else if (irq_req_i || (wake_i && s.min_clk_en))
        begin
          // periodic wake only reachable when the minimal clock set ran
          next_s.cpu_clk_en = 1'b1;
          next_s.osc_en = 1'b1;
          next_s.min_clk_en = 1'b0;
          next_s.software_trap_instruction = 1'b0;
          next_s.idx = 3'h0;
          next_s.state = CILPC_PUSH;
        end
      end
      CILPC_HALT:
      begin
        if (dbg_cmd_valid_i && is_resume(dbg_cmd_i))
        begin
          next_s.state = CILPC_RUN;
          next_s.step = (dbg_cmd_i == CILPC_CMD_STEP);
        end
      end
      default:
      begin
        next_s.state = CILPC_RUN;
      end
    endcase
    // registered copy so the halted output comes straight from a flip-flop
    next_s.halted = (next_s.state == CILPC_HALT);

    // operand address pair, high byte first
    if (opnd_req_i)
    begin
      next_s.hi_addr = opnd_dir_i ? dir_addr(opnd_addr_i[7:0]) : opnd_addr_i;
      next_s.lo_addr = next_s.hi_addr + `CILPC_WORD_STEP;
    end

    // avalon slave: one wait cycle, then the access completes
    next_s.rsp.waitrequest = !(bus_req && s.rsp.waitrequest);
    if (bus_req && s.rsp.waitrequest)
    begin
      unique case (av_req_i.address)
        `CILPC_FLAGS_OFS: next_s.rsp.readdata = {24'h0, s.flags};
        `CILPC_CTRL_OFS: next_s.rsp.readdata = {30'h0, s.keep_clk, s.dbg_en};
        `CILPC_STATUS_OFS: next_s.rsp.readdata = {29'h0, s.state};
        default: next_s.rsp.readdata = 32'h0;
      endcase
    end
    if (bus_go && av_req_i.write)
    begin
      if (av_req_i.address == `CILPC_FLAGS_OFS)
      begin
        next_s.flags = mask_flags(av_req_i.writedata[7:0]);
        // the hardware mask set at the end of a frame wins over software
        if (s.state == CILPC_PUSH && s.idx == `CILPC_PUSH_LAST)
        begin
          next_s.flags[`CILPC_CC_I] = 1'b1;
        end
      end
      if (av_req_i.address == `CILPC_CTRL_OFS)
      begin
        // an enable command in the same cycle is not lost
        next_s.dbg_en = av_req_i.writedata[`CILPC_CTRL_DBGEN] || next_s.dbg_en;
        next_s.keep_clk = av_req_i.writedata[`CILPC_CTRL_KEEPCLK];
      end
    end
  end

  always_ff @(posedge sys_clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      s <= '0;
      s.state <= CILPC_RUN;
      s.flags <= `CILPC_FLAGS_RST;
      {s.keep_clk, s.dbg_en} <= `CILPC_CTRL_RST;
      s.rsp.waitrequest <= 1'b1;
      s.cpu_clk_en <= 1'b1;
      s.osc_en <= 1'b1;
    end
    else if (clk_en_i)
    begin
      s <= next_s;
    end
  end

  assign av_rsp_o = s.rsp;
  assign flags_o = s.flags;
  assign push_o = s.push;
  assign vec_o = s.vec;
  assign cpu_clk_en_o = s.cpu_clk_en;
  assign osc_en_o = s.osc_en;
  assign min_clk_en_o = s.min_clk_en;
  assign halted_o = s.halted;
  assign step_o = s.step;
  assign dbg_en_o = s.dbg_en;
  assign opnd_hi_addr_o = s.hi_addr;
  assign opnd_lo_addr_o = s.lo_addr;

endmodule : cilpc_ctrl

// ===== cilpc_regs.svh
`ifndef CILPC_REGS_SVH
`define CILPC_REGS_SVH

// register byte offsets
`define CILPC_FLAGS_OFS 4'h0
`define CILPC_CTRL_OFS 4'h4
`define CILPC_STATUS_OFS 4'h8

// condition_flags bit positions
`define CILPC_CC_V 7
`define CILPC_CC_H 4
`define CILPC_CC_I 3
`define CILPC_CC_N 2
`define CILPC_CC_Z 1
`define CILPC_CC_C 0
`define CILPC_CC_MASK 8'h9f

// control register bit positions
`define CILPC_CTRL_DBGEN 0
`define CILPC_CTRL_KEEPCLK 1

// reset values
`define CILPC_FLAGS_RST 8'h08
`define CILPC_CTRL_RST 2'h0

// interrupt entry: five stacked bytes, index of the last one
`define CILPC_PUSH_LAST 3'h4
// direct page high byte and 16-bit operand low byte step
`define CILPC_DIR_PAGE 8'h00
`define CILPC_WORD_STEP 16'h0001

`endif

// ===== cilpc_pkg.sv
package cilpc_pkg;

  typedef enum logic [2:0] {
    CILPC_RUN,
    CILPC_PUSH,
    CILPC_VECTOR,
    CILPC_WAIT,
    CILPC_STOP,
    CILPC_HALT
  } cilpc_state_type;

  typedef enum logic [2:0] {
    CILPC_CMD_BACKGROUND,
    CILPC_CMD_RESUME,
    CILPC_CMD_STEP,
    CILPC_CMD_TAGGED_RESUME,
    CILPC_CMD_ENABLE,
    CILPC_CMD_OTHER
  } cilpc_cmd_type;

  typedef struct packed {
    logic read;
    logic write;
    logic [3:0] address;
    logic [31:0] writedata;
  } cilpc_av_req_type;

  typedef struct packed {
    logic waitrequest;
    logic [31:0] readdata;
  } cilpc_av_rsp_type;

  typedef struct packed {
    logic valid;
    logic [15:0] addr;
    logic [7:0] data;
  } cilpc_push_type;

  typedef struct packed {
    logic [15:0] pc;
    logic [7:0] x;
    logic [7:0] a;
    logic [15:0] sp;
  } cilpc_core_regs_type;

  typedef struct packed {
    logic valid;
    logic software_trap_instruction;
  } cilpc_vec_type;

endpackage : cilpc_pkg

// ===== cilpc_props.sv
`timescale 1ns/1ps
module cilpc_props (
  input wire logic sys_clk_i,
  input wire logic arst_n_i,
  input wire logic instr_done_i,
  input wire logic irq_req_i,
  input wire logic swi_exec_i,
  input wire logic wait_exec_i,
  input wire logic debug_entry_instruction_exec_i,
  input wire logic dbg_cmd_valid_i,
  input wire cilpc_pkg::cilpc_cmd_type dbg_cmd_i,
  input wire logic [7:0] flags_o,
  input wire cilpc_pkg::cilpc_push_type push_o,
  input wire cilpc_pkg::cilpc_vec_type vec_o,
  input wire logic cpu_clk_en_o,
  input wire logic halted_o
);
  import cilpc_pkg::*;
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (!arst_n_i);
  // idle run only: boundaries are never driven mid-sequence
  wire logic run = cpu_clk_en_o && !halted_o && !push_o.valid && !vec_o.valid;
  wire logic bnd = instr_done_i && !debug_entry_instruction_exec_i && run;
  a_trap_entry: assert property (
    bnd && swi_exec_i |-> ##2 push_o.valid [*5] ##1 (vec_o.valid && vec_o.software_trap_instruction))
    else $error("trap entry");
  a_irq_masked: assert property (
    bnd && !swi_exec_i && irq_req_i && flags_o[3] |-> ##2 !push_o.valid) else $error("masked");
  a_irq_taken: assert property (
    bnd && irq_req_i && !flags_o[3] |-> ##2 push_o.valid) else $error("irq not taken");
  a_mask_set: assert property (
    push_o.valid && $past(push_o.valid, 4) |-> flags_o[3]) else $error("mask not set");
  a_stack_step: assert property (
    push_o.valid && $past(push_o.valid) |-> push_o.addr == $past(push_o.addr) - 16'h0001)
    else $error("stack address step");
  a_wait_entry: assert property (
    bnd && wait_exec_i && !swi_exec_i && !irq_req_i |=> !cpu_clk_en_o && !flags_o[3])
    else $error("wait entry");
  a_wake_push: assert property (
    !cpu_clk_en_o && !halted_o && irq_req_i |=> cpu_clk_en_o ##1 push_o.valid)
    else $error("wakeup");
  a_debug_entry_instruction_halt: assert property (
    instr_done_i && debug_entry_instruction_exec_i && run |=> halted_o) else $error("debug entry");
  a_halt_hold: assert property (
    halted_o && !(dbg_cmd_valid_i && (dbg_cmd_i inside {CILPC_CMD_RESUME, CILPC_CMD_STEP,
    CILPC_CMD_TAGGED_RESUME})) |=> halted_o) else $error("left debug state");
  c_trap: cover property (vec_o.valid && vec_o.software_trap_instruction);
  c_wake: cover property (!cpu_clk_en_o && irq_req_i);
  c_leave: cover property (halted_o ##1 !halted_o);
endmodule : cilpc_props

// ===== cilpc_host.sv
`timescale 1ns/1ps
module cilpc_host (
  input wire logic sys_clk_i,
  input wire logic send_i,
  input wire cilpc_pkg::cilpc_cmd_type cmd_i,
  output logic dbg_cmd_valid_o = 1'b0,
  output cilpc_pkg::cilpc_cmd_type dbg_cmd_o = cilpc_pkg::CILPC_CMD_OTHER
);
  import cilpc_pkg::*;
  // idle code walks so a stale command never looks held
  always @(posedge sys_clk_i)
  begin
    dbg_cmd_valid_o <= send_i;
    dbg_cmd_o <= send_i ? cmd_i : cilpc_cmd_type'(dbg_cmd_o + 3'h1);
  end
endmodule : cilpc_host

// ===== tb_top.sv
`timescale 1ns/1ps
module tb_top;
  import cilpc_pkg::*;
  logic clk, arst_n, done, irq, oreq, odir, send, dval;
  logic cpu_en, osc_en, min_en, halted, stp, dbg_en, wake, strap;
  logic [3:0] ex;
  logic [7:0] flags;
  logic [15:0] oaddr, hi, lo;
  logic [31:0] q;
  cilpc_av_req_type req;
  cilpc_av_rsp_type rsp;
  cilpc_core_regs_type regs;
  cilpc_push_type push;
  cilpc_vec_type vec;
  cilpc_cmd_type hcmd, dcmd;
  int fail_count, checks, cyc, n;
  cilpc_ctrl i_dut (.sys_clk_i(clk), .arst_n_i(arst_n), .clk_en_i(1'b1), .av_req_i(req),
    .av_rsp_o(rsp), .core_regs_i(regs), .instr_done_i(done), .irq_req_i(irq), .wake_i(wake),
    .swi_exec_i(ex[3]), .wait_exec_i(ex[2]), .stop_exec_i(ex[1]), .debug_entry_instruction_exec_i(ex[0]),
    .flags_wr_i(1'b0), .flags_data_i(8'h00), .dbg_cmd_valid_i(dval), .dbg_cmd_i(dcmd),
    .dbg_strap_i(strap), .opnd_req_i(oreq), .opnd_dir_i(odir), .opnd_addr_i(oaddr),
    .flags_o(flags), .push_o(push), .vec_o(vec), .cpu_clk_en_o(cpu_en), .osc_en_o(osc_en),
    .min_clk_en_o(min_en), .halted_o(halted), .step_o(stp), .dbg_en_o(dbg_en),
    .opnd_hi_addr_o(hi), .opnd_lo_addr_o(lo));
  cilpc_host i_host (.sys_clk_i(clk), .send_i(send), .cmd_i(hcmd), .dbg_cmd_valid_o(dval),
    .dbg_cmd_o(dcmd));
  task complete_run;
    if (fail_count == 0 && checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : complete_run
  task chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp)
    begin
      fail_count++;
      $display("ERROR %0t: got %h exp %h", $time, got, exp);
    end
  endtask : chk
  task bus(input logic rd, input logic [3:0] a, input logic [31:0] d);
    @(posedge clk);
    req <= '{rd, !rd, a, d};
    @(posedge clk);
    while (rsp.waitrequest !== 1'b0)
      @(posedge clk);
    q = rsp.readdata;
    req <= '0;
  endtask : bus
  task step(input logic [3:0] k);
    @(posedge clk);
    done <= 1'b1;
    ex <= k;
    @(posedge clk);
    done <= 1'b0;
    ex <= 4'h0;
  endtask : step
  task host(input cilpc_cmd_type c);
    @(posedge clk);
    send <= 1'b1;
    hcmd <= c;
    @(posedge clk);
    send <= 1'b0;
    repeat (2) @(posedge clk);
  endtask : host
  // extra pushes index past the table and read as unknown, so they fail
  task scan(input int cnt, input logic [7:0] f);
    logic [7:0] b [5];
    b = '{regs.pc[7:0], regs.pc[15:8], regs.x, regs.a, f};
    n = 0;
    repeat (10)
    begin
      @(posedge clk);
      if (push.valid === 1'b1)
      begin
        chk(push.data, b[n]);
        chk(push.addr, 16'(regs.sp - n));
        n++;
      end
    end
    chk(n, cnt);
  endtask : scan
  task opnd(input logic d, input logic [15:0] a, input logic [15:0] h);
    @(posedge clk);
    oreq <= 1'b1;
    odir <= d;
    oaddr <= a;
    @(posedge clk);
    oreq <= 1'b0;
    @(posedge clk);
    chk({hi, lo}, {h, h + 16'h0001});
  endtask : opnd
  initial
  begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 3000)
    begin
      fail_count++;
      complete_run;
    end
  end
  initial
  begin
    arst_n = 1'b0;
    {done, irq, oreq, odir, send, wake, strap} = '0;
    oaddr = 16'h0000;
    hcmd = CILPC_CMD_OTHER;
    ex = 4'h0;
    req = '0;
    regs = '{16'h1234, 8'h56, 8'h78, 16'h00ff};
    repeat (16) @(posedge clk);
    arst_n <= 1'b1;
    repeat (2) @(posedge clk);
    bus(1'b1, 4'h0, 32'h0);
    chk(q, 32'h08);
    bus(1'b0, 4'h0, 32'hff);
    bus(1'b1, 4'h0, 32'h0);
    chk(q, 32'h9f);
    bus(1'b1, 4'hc, 32'h0);
    chk(q, 32'h0);
    bus(1'b0, 4'h0, 32'h0);
    irq <= 1'b1;
    step(4'h0);
    scan(5, 8'h00);
    chk(flags, 32'h08);
    step(4'h0);
    scan(0, 8'h00);
    irq <= 1'b0;
    step(4'h8);
    scan(5, 8'h08);
    step(4'h4);
    @(posedge clk);
    chk({cpu_en, flags}, 32'h0);
    irq <= 1'b1;
    scan(5, 8'h00);
    irq <= 1'b0;
    bus(1'b0, 4'h0, 32'h0);
    step(4'h2);
    host(CILPC_CMD_BACKGROUND);
    chk({halted, cpu_en, osc_en}, 32'h0);
    irq <= 1'b1;
    scan(5, 8'h00);
    irq <= 1'b0;
    step(4'h4);
    host(CILPC_CMD_BACKGROUND);
    chk({halted, cpu_en}, 32'h3);
    host(CILPC_CMD_OTHER);
    chk(halted, 32'h1);
    for (int i = 1; i < 4; i++)
    begin
      host(cilpc_cmd_type'(i));
      chk({halted, stp}, 32'(i == 2));
      step(4'h1);
      @(posedge clk);
      chk(halted, 32'h1);
    end
    host(CILPC_CMD_ENABLE);
    chk(dbg_en, 32'h1);
    host(CILPC_CMD_RESUME);
    bus(1'b0, 4'h4, 32'h2);
    bus(1'b1, 4'h4, 32'h0);
    chk(q, 32'h3);
    step(4'h2);
    @(posedge clk);
    chk({osc_en, min_en, cpu_en}, 32'h6);
    host(CILPC_CMD_BACKGROUND);
    chk({halted, cpu_en}, 32'h3);
    host(CILPC_CMD_RESUME);
    chk(halted, 32'h0);
    step(4'h2);
    wake <= 1'b1;
    scan(5, 8'h00);
    wake <= 1'b0;
    opnd(1'b1, 16'habcd, 16'h00cd);
    opnd(1'b0, 16'h12ff, 16'h12ff);
    strap <= 1'b1;
    arst_n <= 1'b0;
    repeat (2) @(posedge clk);
    arst_n <= 1'b1;
    repeat (4) @(posedge clk);
    chk({halted, dbg_en}, 32'h3);
    complete_run;
  end
endmodule : tb_top
bind cilpc_ctrl cilpc_props i_props (.sys_clk_i(sys_clk_i), .arst_n_i(arst_n_i),
  .instr_done_i(instr_done_i), .irq_req_i(irq_req_i), .swi_exec_i(swi_exec_i),
  .wait_exec_i(wait_exec_i), .debug_entry_instruction_exec_i(debug_entry_instruction_exec_i), .dbg_cmd_valid_i(dbg_cmd_valid_i),
  .dbg_cmd_i(dbg_cmd_i), .flags_o(flags_o), .push_o(push_o), .vec_o(vec_o),
  .cpu_clk_en_o(cpu_clk_en_o), .halted_o(halted_o));
